//--- rtl/rsb_readout_bank.sv
// Purpose: Paged status readout bank behind an AXI4-Lite slave
// Assumes: Status inputs are synchronous to CLOCK
// Notes:   Byte address is four times the register index
//
// Operation
// RL1: Page bits 7:6 steer the converter view
// RL2: Page bits 5:4 steer the calibration view
// RL3: Strength page 0000 shows live I/Q
// RL4: Page 0010 shows quiet level from store command
// RL5: Pages 0100/0110/1000: pilot, second byte, peak
// RL6: Pages 1100/1101: collision time and duration
// RL7: Page 1110 error time; others unused
// RL8: Health bit 7 shows sub-carrier phase
// RL9: Health bits 6:4 show gain control state
// RL10: Health bit 3 shows decoder channel
// RL11: Health bit 2 shows carrier level stable
// RL12: Health bit 1 shows synthesiser lock
// RL13: Health bit 0 shows oscillator stable
// RL14: Strength bits 7:4 carry Q level
// RL15: Strength bits 3:0 carry I level
// RL16: Writes to read-only ignored; reads live
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
module rsb_readout_bank (
    input  wire logic                     CLOCK,
    input  wire logic                     RST_B,
    // AXI4-Lite write address
    input  wire logic [rsb_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic                     S_AXI_AWVALID,
    output logic                          S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire logic [rsb_pkg::DATA_W-1:0] S_AXI_WDATA,
    input  wire logic [3:0]               S_AXI_WSTRB,
    input  wire logic                     S_AXI_WVALID,
    output logic                          S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0]                    S_AXI_BRESP,
    output logic                          S_AXI_BVALID,
    input  wire logic                     S_AXI_BREADY,
    // AXI4-Lite read address
    input  wire logic [rsb_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic                     S_AXI_ARVALID,
    output logic                          S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [rsb_pkg::DATA_W-1:0]    S_AXI_RDATA,
    output logic [1:0]                    S_AXI_RRESP,
    output logic                          S_AXI_RVALID,
    input  wire logic                     S_AXI_RREADY,
    // Receiver and health status
    input  wire rsb_pkg::rsb_health_t     HEALTH,
    input  wire rsb_pkg::rsb_strength_t   STRENGTH_LIVE,
    input  wire logic                     STORE_STRENGTH,
    input  wire logic                     PILOT_SEEN,
    input  wire logic                     SECOND_BYTE_SEEN,
    input  wire logic                     RX_START,
    input  wire logic [7:0]               COLLISION_THRESHOLD_TIME,
    input  wire logic [7:0]               COLLISION_THRESHOLD_DURATION,
    input  wire logic [7:0]               PROTOCOL_ERROR_TIME,
    // Calibration and converter status
    input  wire logic [5:0]               AGL_STATUS,
    input  wire logic [3:0]               VCO_RANGE,
    input  wire logic [2:0]               VCO_VOLTAGE,
    input  wire logic [3:0]               HP_CAL,
    input  wire logic [3:0]               LP_CAL,
    input  wire logic [7:0]               ADC_RESULT,
    input  wire logic                     TCXO_MODE,
    input  wire logic [2:0]               SUPPLY_SETTING
);
    import rsb_pkg::*;

    logic [7:0]        page_sel;
    logic [1:0]        adc_view_page;
    logic [1:0]        cal_view_page;
    logic [3:0]        strength_view_page;
    rsb_snap_t         snap;

    logic              aw_held;
    logic              w_held;
    logic [5:0]        aw_idx;
    logic [7:0]        w_byte;
    logic              w_lane0;
    logic              wr_go;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              page_wr;
    logic              wr_page_hit;
    logic              wr_known;

    logic              rvalid;
    logic [1:0]        rresp;
    logic [DATA_W-1:0] rdata;
    logic              rd_go;
    logic [5:0]        ar_idx;

    logic [7:0]        health_view;
    logic [7:0]        strength_view;
    logic [7:0]        cal_view;
    logic [7:0]        adc_view;
    logic [7:0]        next_rbyte;
    logic              next_rhit;

    rsb_strength_capture u_capture (
        .clk            (CLOCK),
        .rst_b          (RST_B),
        .live           (STRENGTH_LIVE),
        .store_quiet    (STORE_STRENGTH),
        .at_pilot       (PILOT_SEEN),
        .at_second_byte (SECOND_BYTE_SEEN),
        .rx_start       (RX_START),
        .snap           (snap)
    );

    // Write channel: address and data taken in either order
    assign S_AXI_AWREADY = !aw_held && !bvalid;
    assign S_AXI_WREADY  = !w_held && !bvalid;
    assign wr_go         = aw_held && w_held && !bvalid;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            aw_held <= 1'h0;
            aw_idx  <= 6'h00;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held <= 1'h1;
            aw_idx  <= S_AXI_AWADDR[7:2];
        end else if (wr_go) begin
            aw_held <= 1'h0;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            w_held  <= 1'h0;
            w_byte  <= 8'h00;
            w_lane0 <= 1'h0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held  <= 1'h1;
            w_byte  <= S_AXI_WDATA[7:0];
            w_lane0 <= S_AXI_WSTRB[0];
        end else if (wr_go) begin
            w_held <= 1'h0;
        end
    end

    // Decode once so the store and the response agree on the target
    always_comb begin
        wr_page_hit = 1'h0;
        wr_known    = 1'h1;
        unique case (aw_idx)
            IDX_PAGE_SEL: begin
                wr_page_hit = 1'h1;
            end
            IDX_HEALTH, IDX_STRENGTH, IDX_CAL_VIEW, IDX_ADC_VIEW: begin
                wr_known = 1'h1; // [RL16]
            end
            default: begin
                wr_known = 1'h0;
            end
        endcase
    end

    // Only the page-select word stores; status words drop the data
    assign page_wr = wr_go && wr_page_hit && w_lane0; // [RL16]

    // One flop group per field so each view page has a single owner
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            adc_view_page <= PAGE_SEL_RST[ADC_PG_MSB:ADC_PG_LSB]; // [RL1]
        end else if (page_wr) begin
            adc_view_page <= w_byte[ADC_PG_MSB:ADC_PG_LSB]; // [RL1]
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            cal_view_page <= PAGE_SEL_RST[CAL_PG_MSB:CAL_PG_LSB]; // [RL2]
        end else if (page_wr) begin
            cal_view_page <= w_byte[CAL_PG_MSB:CAL_PG_LSB]; // [RL2]
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            strength_view_page <= PAGE_SEL_RST[STR_PG_MSB:STR_PG_LSB]; // [RL3]
        end else if (page_wr) begin
            strength_view_page <= w_byte[STR_PG_MSB:STR_PG_LSB]; // [RL3]
        end
    end

    assign page_sel = {adc_view_page, cal_view_page, strength_view_page};

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            bvalid <= 1'h0;
            bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'h1;
            bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR; // [RL16]
        end else if (S_AXI_BREADY) begin
            bvalid <= 1'h0;
        end
    end

    assign S_AXI_BVALID = bvalid;
    assign S_AXI_BRESP  = bresp;

    // Health word maps the struct straight onto bits 7:0
    always_comb begin
        health_view[7]   = HEALTH.subc_phase; // [RL8]
        health_view[6:4] = HEALTH.agc_state; // [RL9]
        health_view[3]   = HEALTH.in_select; // [RL10]
        health_view[2]   = HEALTH.carrier_level_stable; // [RL11]
        health_view[1]   = HEALTH.pll_locked; // [RL12]
        health_view[0]   = HEALTH.osc_stable; // [RL13]
    end

    // Unused page codes read as zero
    always_comb begin
        strength_view = 8'h00; // [RL7]
        unique case (strength_view_page)
            STR_LIVE: begin
                strength_view = {STRENGTH_LIVE.q, STRENGTH_LIVE.i}; // [RL3] [RL14] [RL15]
            end
            STR_QUIET: begin
                strength_view = {snap.quiet.q, snap.quiet.i}; // [RL4] [RL14] [RL15]
            end
            STR_PILOT: begin
                strength_view = {snap.pilot.q, snap.pilot.i}; // [RL5]
            end
            STR_SECOND: begin
                strength_view = {snap.second_byte.q, snap.second_byte.i}; // [RL5]
            end
            STR_PEAK: begin
                strength_view = {snap.peak.q, snap.peak.i}; // [RL5]
            end
            STR_COL_TIME: begin
                strength_view = COLLISION_THRESHOLD_TIME; // [RL6]
            end
            STR_COL_DUR: begin
                strength_view = COLLISION_THRESHOLD_DURATION; // [RL6]
            end
            STR_ERR_TIME: begin
                strength_view = PROTOCOL_ERROR_TIME; // [RL7]
            end
            default: begin
                strength_view = 8'h00; // [RL7]
            end
        endcase
    end

    always_comb begin
        cal_view = 8'h00;
        unique case (cal_view_page)
            CAL_PG_AGL: begin
                cal_view = {2'h0, AGL_STATUS}; // [RL2]
            end
            CAL_PG_VCO: begin
                cal_view = {VCO_RANGE, 1'h1, VCO_VOLTAGE}; // [RL2]
            end
            CAL_PG_FILT: begin
                cal_view = {HP_CAL, LP_CAL}; // [RL2]
            end
            default: begin
                cal_view = 8'h00;
            end
        endcase
    end

    always_comb begin
        adc_view = 8'h00;
        unique case (adc_view_page)
            ADC_PG_ADC: begin
                adc_view = ADC_RESULT; // [RL1]
            end
            ADC_PG_SUPPLY: begin
                adc_view = {TCXO_MODE, 4'h0, SUPPLY_SETTING}; // [RL1]
            end
            default: begin
                adc_view = 8'h00;
            end
        endcase
    end

    // Read channel: one outstanding read, data sampled when taken
    assign S_AXI_ARREADY = !rvalid;
    assign rd_go         = S_AXI_ARVALID && !rvalid;
    assign ar_idx        = S_AXI_ARADDR[7:2];

    // Status is read as it stands now; nothing is latched ahead of the read
    always_comb begin
        next_rbyte = 8'h00;
        next_rhit  = 1'h1;
        unique case (ar_idx)
            IDX_PAGE_SEL: begin
                next_rbyte = page_sel;
            end
            IDX_HEALTH: begin
                next_rbyte = health_view;
            end
            IDX_STRENGTH: begin
                next_rbyte = strength_view; // [RL16]
            end
            IDX_CAL_VIEW: begin
                next_rbyte = cal_view;
            end
            IDX_ADC_VIEW: begin
                next_rbyte = adc_view;
            end
            default: begin
                next_rhit = 1'h0;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rvalid <= 1'h0;
        end else if (rd_go) begin
            rvalid <= 1'h1;
        end else if (S_AXI_RREADY) begin
            rvalid <= 1'h0;
        end
    end

    // Upper bits always zero; only the low byte is implemented
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rdata <= 32'h0000_0000;
        end else if (rd_go) begin
            rdata <= {24'h00_0000, next_rbyte}; // [RL16]
        end
    end

    // Unmapped indices answer with an error so software sees the miss
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rresp <= RESP_OKAY;
        end else if (rd_go) begin
            rresp <= next_rhit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    assign S_AXI_RVALID = rvalid;
    assign S_AXI_RDATA  = rdata;
    assign S_AXI_RRESP  = rresp;
endmodule

//--- rtl/rsb_pkg.sv
// Purpose: Shared constants and types of the status readout bank
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes:   Byte address of a register is four times its index
package rsb_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    // Register indices
    localparam logic [5:0]  IDX_PAGE_SEL  = 6'h29;
    localparam logic [5:0]  IDX_HEALTH    = 6'h2a;
    localparam logic [5:0]  IDX_STRENGTH  = 6'h2b;
    localparam logic [5:0]  IDX_CAL_VIEW  = 6'h2c;
    localparam logic [5:0]  IDX_ADC_VIEW  = 6'h2d;
    localparam logic [7:0]  PAGE_SEL_RST  = 8'h00;
    // Page-select field positions
    localparam int          ADC_PG_MSB    = 7;
    localparam int          ADC_PG_LSB    = 6;
    localparam int          CAL_PG_MSB    = 5;
    localparam int          CAL_PG_LSB    = 4;
    localparam int          STR_PG_MSB    = 3;
    localparam int          STR_PG_LSB    = 0;
    // Strength page codes
    localparam logic [3:0]  STR_LIVE      = 4'h0;
    localparam logic [3:0]  STR_QUIET     = 4'h2;
    localparam logic [3:0]  STR_PILOT     = 4'h4;
    localparam logic [3:0]  STR_SECOND    = 4'h6;
    localparam logic [3:0]  STR_PEAK      = 4'h8;
    localparam logic [3:0]  STR_COL_TIME  = 4'hc;
    localparam logic [3:0]  STR_COL_DUR   = 4'hd;
    localparam logic [3:0]  STR_ERR_TIME  = 4'he;
    // Calibration and converter view pages
    localparam logic [1:0]  CAL_PG_AGL    = 2'h0;
    localparam logic [1:0]  CAL_PG_VCO    = 2'h1;
    localparam logic [1:0]  CAL_PG_FILT   = 2'h2;
    localparam logic [1:0]  ADC_PG_ADC    = 2'h0;
    localparam logic [1:0]  ADC_PG_SUPPLY = 2'h1;
    // Bus responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef struct packed {
        logic       subc_phase;
        logic [2:0] agc_state;
        logic       in_select;
        logic       carrier_level_stable;
        logic       pll_locked;
        logic       osc_stable;
    } rsb_health_t;

    typedef struct packed {
        logic [3:0] q;
        logic [3:0] i;
    } rsb_strength_t;

    typedef struct packed {
        rsb_strength_t quiet;
        rsb_strength_t pilot;
        rsb_strength_t second_byte;
        rsb_strength_t peak;
    } rsb_snap_t;
endpackage

//--- rtl/rsb_strength_capture.sv
// Purpose: Holds the captured I/Q strength levels per channel
// Assumes: Strobes are one-cycle pulses from the receiver
// Notes:   Peak restarts from the live level at reception start
`timescale 1ns/10ps
module rsb_strength_capture (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire rsb_pkg::rsb_strength_t live,
    input  wire logic                  store_quiet,
    input  wire logic                  at_pilot,
    input  wire logic                  at_second_byte,
    input  wire logic                  rx_start,
    output rsb_pkg::rsb_snap_t         snap
);
    import rsb_pkg::*;

    logic [1:0][3:0] live_ch;
    logic [1:0][3:0] quiet_ch;
    logic [1:0][3:0] pilot_ch;
    logic [1:0][3:0] second_ch;
    logic [1:0][3:0] peak_ch;

    assign live_ch = {live.q, live.i};

    // Channel 0 is I, channel 1 is Q
    for (genvar c = 0; c < 2; c++) begin : g_ch
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                quiet_ch[c] <= 4'h0;
            end else if (store_quiet) begin
                quiet_ch[c] <= live_ch[c]; // [RL4]
            end
        end

        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                pilot_ch[c]  <= 4'h0;
                second_ch[c] <= 4'h0;
            end else begin
                if (at_pilot) begin
                    pilot_ch[c] <= live_ch[c]; // [RL5]
                end
                if (at_second_byte) begin
                    second_ch[c] <= live_ch[c]; // [RL5]
                end
            end
        end

        // Restart wins over tracking so a new frame never inherits an old peak
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                peak_ch[c] <= 4'h0;
            end else if (rx_start || live_ch[c] > peak_ch[c]) begin
                peak_ch[c] <= live_ch[c]; // [RL5]
            end
        end
    end

    // One driver for the whole struct; field order as the package declares it
    assign snap = {quiet_ch[1], quiet_ch[0], pilot_ch[1], pilot_ch[0],
                   second_ch[1], second_ch[0], peak_ch[1], peak_ch[0]};
endmodule

//--- verification/rsb_readout_bank_chk.sv
// Purpose: Bus and readout checks for the status readout bank
// Assumes: Bound to rsb_readout_bank, one clock domain
// Notes:   Sees top-level ports only
`timescale 1ns/10ps
module rsb_readout_bank_chk (
    input wire logic                        CLOCK,
    input wire logic                        RST_B,
    input wire logic                        S_AXI_AWREADY,
    input wire logic                        S_AXI_WREADY,
    input wire logic [1:0]                  S_AXI_BRESP,
    input wire logic                        S_AXI_BVALID,
    input wire logic                        S_AXI_BREADY,
    input wire logic [rsb_pkg::ADDR_W-1:0]  S_AXI_ARADDR,
    input wire logic                        S_AXI_ARVALID,
    input wire logic                        S_AXI_ARREADY,
    input wire logic [rsb_pkg::DATA_W-1:0]  S_AXI_RDATA,
    input wire logic [1:0]                  S_AXI_RRESP,
    input wire logic                        S_AXI_RVALID,
    input wire logic                        S_AXI_RREADY,
    input wire rsb_pkg::rsb_health_t        HEALTH
);
    import rsb_pkg::*;
    logic ar_take;
    logic mapped;
    assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
    assign mapped  = (S_AXI_ARADDR[7:2] >= IDX_PAGE_SEL) && (S_AXI_ARADDR[7:2] <= IDX_ADC_VIEW);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    a_write_refused: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write channel ready during response");
    a_read_refused: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read address ready during read data");
    a_read_answer: assert property (ar_take |=> S_AXI_RVALID)
        else $error("read data late");
    a_read_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA)
        && $stable(S_AXI_RRESP)) else $error("read data dropped or changed");
    a_resp_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped or changed");
    a_health_bits: assert property (ar_take && S_AXI_ARADDR[7:2] == IDX_HEALTH
        |=> S_AXI_RDATA == {24'h0, $past(HEALTH)}) else $error("health read mismatch");
    a_unmapped_err: assert property (ar_take && !mapped |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_okay: assert property (ar_take && mapped
        |=> S_AXI_RRESP == RESP_OKAY && S_AXI_RDATA[31:8] == 24'h0) else $error("mapped read bad");

    c_health_read: cover property (ar_take && S_AXI_ARADDR[7:2] == IDX_HEALTH);
    c_write_done: cover property (S_AXI_BVALID && S_AXI_BREADY);
    c_slverr: cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);
endmodule

bind rsb_readout_bank rsb_readout_bank_chk u_chk (.CLOCK(CLOCK), .RST_B(RST_B), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .HEALTH(HEALTH));

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the status readout bank
// Assumes: AXI4-Lite master in the bench, inputs driven on rising edges
// Notes:   Page rows first, then refusals and a mid-run reset
`timescale 1ns/10ps
module tb_top;
    import rsb_pkg::*;
    logic          clock, rst_b, awvalid, wvalid, bready, arvalid, rready;
    logic          awready, wready, bvalid, arready, rvalid, store, pilot, second, rx_start, tcxo;
    logic [7:0]    awaddr, araddr, col_time, col_dur, err_time, adc;
    logic [31:0]   wdata, rdata, d;
    logic [3:0]    wstrb, vco_range, hp_cal, lp_cal;
    logic [1:0]    bresp, rresp, r;
    logic [5:0]    agl;
    logic [2:0]    vco_volt, supply;
    rsb_health_t   health;
    rsb_strength_t live;
    int            fail_count, samples_checked, cycles;
    // {page, byte address, expected byte}
    logic [23:0]   rows [19] = '{24'h00ac39, 24'h02ac21, 24'h04ac43, 24'h06ac65, 24'h08ac89, 24'h0caca5,
        24'h0dac5a, 24'h0eacc3, 24'h01ac00, 24'h0fac00, 24'h00b02d, 24'h10b0ad, 24'h20b069, 24'h30b000,
        24'h00b47e, 24'h40b486, 24'h80b400, 24'hc0b400, 24'hf3a8b5};

    rsb_readout_bank uut (.CLOCK(clock), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .HEALTH(health),
        .STRENGTH_LIVE(live), .STORE_STRENGTH(store), .PILOT_SEEN(pilot), .SECOND_BYTE_SEEN(second),
        .RX_START(rx_start), .COLLISION_THRESHOLD_TIME(col_time), .COLLISION_THRESHOLD_DURATION(col_dur),
        .PROTOCOL_ERROR_TIME(err_time), .AGL_STATUS(agl), .VCO_RANGE(vco_range), .VCO_VOLTAGE(vco_volt),
        .HP_CAL(hp_cal), .LP_CAL(lp_cal), .ADC_RESULT(adc), .TCXO_MODE(tcxo), .SUPPLY_SETTING(supply));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Each channel released only after its own handshake edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] q);
        @(posedge clock);
        awaddr  <= a;
        wdata   <= v;
        wstrb   <= s;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        do begin
            @(posedge clock);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        q = bresp;
        bready <= 1'h0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] q);
        @(posedge clock);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do begin
            @(posedge clock);
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        v = rdata;
        q = rresp;
        rready <= 1'h0;
    endtask

    // Strobe kinds: 0 store, 1 pilot, 2 second byte, 3 reception start
    task automatic strobe(input int k, input logic [7:0] v);
        @(posedge clock);
        live     <= v;
        store    <= (k == 0);
        pilot    <= (k == 1);
        second   <= (k == 2);
        rx_start <= (k == 3);
        @(posedge clock);
        {store, pilot, second, rx_start} <= 4'h0;
    endtask

    initial begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end

    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        {rst_b, awvalid, wvalid, bready, arvalid, rready, store, pilot, second, rx_start} = 10'h0;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        {col_time, col_dur, err_time, adc, agl, vco_range, vco_volt} = {32'ha55ac37e, 6'h2d, 4'ha, 3'h5};
        {hp_cal, lp_cal, tcxo, supply, health, live} = {4'h6, 4'h9, 1'h1, 3'h6, 8'hb5, 8'h00};
        repeat (3) @(posedge clock);
        rst_b <= 1'h1;
        axi_rd(8'ha4, d, r);
        chk("page after reset", d, 32'h0);
        strobe(0, 8'h21);
        strobe(1, 8'h43);
        strobe(2, 8'h65);
        // Peak keeps the per-channel maximum since reception start
        strobe(3, 8'h12);
        live <= 8'h87;
        @(posedge clock);
        live <= 8'h39;
        for (int n = 0; n < 19; n++) begin
            axi_wr(8'ha4, {24'h0, rows[n][23:16]}, 4'hf, r);
            chk("page write resp", 32'(r), 32'(RESP_OKAY));
            axi_rd(rows[n][15:8], d, r);
            chk("view", d, {24'h0, rows[n][7:0]});
            chk("view resp", 32'(r), 32'(RESP_OKAY));
            axi_rd(8'ha4, d, r);
            chk("page readback", d, {24'h0, rows[n][23:16]});
        end
        health <= 8'h4a;
        axi_rd(8'ha8, d, r);
        chk("health", d, 32'h4a);
        axi_wr(8'ha4, 32'h0, 4'hf, r);
        live <= 8'hf0;
        axi_rd(8'hac, d, r);
        chk("live strength", d, 32'hf0);
        axi_wr(8'hac, 32'hff, 4'hf, r);
        chk("ro write resp", 32'(r), 32'(RESP_OKAY));
        axi_wr(8'ha8, 32'hff, 4'hf, r);
        chk("ro health write resp", 32'(r), 32'(RESP_OKAY));
        axi_wr(8'ha4, 32'hff, 4'h0, r);
        axi_rd(8'ha4, d, r);
        chk("page kept", d, 32'h0);
        axi_wr(8'h00, 32'h5c, 4'hf, r);
        chk("unmapped write resp", 32'(r), 32'(RESP_SLVERR));
        axi_rd(8'hfc, d, r);
        chk("unmapped read", d, 32'h0);
        chk("unmapped read resp", 32'(r), 32'(RESP_SLVERR));
        axi_wr(8'ha4, 32'hff, 4'hf, r);
        axi_rd(8'ha4, d, r);
        chk("page before reset", d, 32'hff);
        @(posedge clock);
        rst_b <= 1'h0;
        repeat (3) @(posedge clock);
        rst_b <= 1'h1;
        axi_rd(8'ha4, d, r);
        chk("page after second reset", d, 32'h0);
        end_of_test();
    end
endmodule
